/* src/mss_speed_search.sv */
// speed search sequencer for a coasting motor, with register port
`timescale 1ns/1ps
`default_nettype none
module mss_speed_search
    import mss_pkg::*;
#(
    parameter int unsigned TENTH_TICKS = TENTH_CYCLES,
    parameter int unsigned MS_TICKS = MS_CYCLES
) (
    input wire logic i_clk_sys, // system clock, 125 MHz
    input wire logic i_resetn, // async reset, active low
    input wire logic [3:0] i_addr, // register index
    input wire logic [15:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [15:0] o_rdata, // read data, cycle after strobe
    input wire logic i_run, // run contact, pin
    input wire logic i_power_ok, // supply present, pin
    input wire logic [1:0] i_din, // programmable inputs, pins
    input wire logic [15:0] i_freq_ref, // frequency reference
    input wire logic [7:0] i_out_current, // output current, percent rated
    input wire logic i_est_valid, // estimator result ready
    input wire logic [15:0] i_est_speed, // estimated shaft frequency
    input wire logic i_est_dir, // estimated direction, 1 = reverse
    output logic o_out_enable, // output bridge on
    output logic [15:0] o_out_freq, // output frequency
    output logic o_out_dir, // output direction, 1 = reverse
    output logic o_search_active, // search in progress
    output logic o_est_start // one-cycle estimator request
);

    // settings
    logic [1:0] method_sel;
    logic bidir;

    // one code byte per input
    logic [15:0] din_func;
    // search limits and timing
    logic [7:0] exit_cur;
    logic [7:0] decel_time;
    logic [7:0] search_delay;
    logic [7:0] min_off;
    logic [15:0] max_freq;
    logic [15:0] min_freq;

    // sequencer
    mss_state_t state;
    // method of the last run edge
    logic [1:0] method_q;
    // search again once off ends
    logic recovery;
    // sweep pacing accumulator
    logic [23:0] acc;

    // pin sync and edge history
    logic run_m, run_s, run_d, pwr_m, pwr_s;
    logic [1:0] din_m, din_s, din_d;

    // millisecond prescaler
    localparam int unsigned MW = $clog2(MS_TICKS + 1);
    logic [MW-1:0] ms_pre;
    logic ms_tick;

    // tenth timer handshake
    logic tmr_load;
    logic [7:0] tmr_value;
    logic tmr_done;


    // keep a written value legal
    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
        clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp8


    // closed input with this code
    function automatic logic din_hit(input logic [1:0] lvl, input logic [15:0] fn,
                                     input logic [7:0] code);
        din_hit = (lvl[0] && fn[7:0] == code) || (lvl[1] && fn[15:8] == code);
    endfunction : din_hit

    // input decode from synchronised pins
    wire run_rise = run_s & ~run_d;
    wire ss1 = din_hit(din_s, din_func, FUNC_SEARCH1);
    wire ss2 = din_hit(din_s, din_func, FUNC_SEARCH2);
    wire ss_rise = din_hit(din_s & ~din_d, din_func, FUNC_SEARCH1)
        | din_hit(din_s & ~din_d, din_func, FUNC_SEARCH2);
    wire din_any = ss1 | ss2;

    // run edge needs supply present
    wire idle_start = (state == ST_IDLE) && run_rise && pwr_s;

    // start search: selections 1,3 always; any selection for an input run
    wire start_search = method_sel[0] | din_any;
    wire go_search = (idle_start && start_search)
        || (state == ST_DELAY && tmr_done && run_s && pwr_s);

    wire [1:0] meth_now = (state == ST_IDLE) ? method_sel : method_q;
    wire use_sweep = meth_now[1];
    wire [15:0] sweep_start = ss2 ? i_freq_ref : max_freq;

    // output-off time floored by search delay when start search is on
    wire [7:0] off_time = (method_q[0] && search_delay > min_off) ? search_delay
        : min_off;

    // causes that drop the bridge
    wire lose_out = !pwr_s || !run_s || ss_rise;

    // full span falls in decel time
    wire [15:0] span = (max_freq > min_freq) ? max_freq - min_freq : 16'h0000;
    wire [23:0] thr = 24'(decel_time) * 24'(MS_PER_TENTH);
    wire sweep_step = (acc >= thr) && (o_out_freq > min_freq);

    wire cur_match = i_out_current < exit_cur;

    wire est_keep = bidir || (i_est_dir == o_out_dir);
    wire [15:0] est_freq = (i_est_speed > max_freq) ? max_freq : i_est_speed;

    // status word and read mux
    wire [15:0] status = {4'h0, method_q, o_search_active, o_out_dir, o_out_enable,
        1'b0, state};
    wire [15:0] rd_mux =
        (i_addr == REG_MODE) ? {13'h0000, bidir, method_sel} :
        (i_addr == REG_DIN_FUNC) ? din_func :
        (i_addr == REG_EXIT_CUR) ? {8'h00, exit_cur} :
        (i_addr == REG_DECEL) ? {8'h00, decel_time} :
        (i_addr == REG_DELAY) ? {8'h00, search_delay} :
        (i_addr == REG_MIN_OFF) ? {8'h00, min_off} :
        (i_addr == REG_MAX_FREQ) ? max_freq :
        (i_addr == REG_MIN_FREQ) ? min_freq :
        (i_addr == REG_STATUS) ? status :
        (i_addr == REG_OUT_FREQ) ? o_out_freq : 16'h0000;

    // timer loads: off time on output loss, search delay once the off time is over with supply present
    assign tmr_load = (lose_out && (state == ST_RUN || state == ST_EST
        || state == ST_SWEEP)) || (state == ST_OFF && tmr_done && recovery && pwr_s);
    assign tmr_value = (state == ST_OFF) ? search_delay : off_time;


    mss_tenth_timer #(
        .TICK_CYCLES(TENTH_TICKS)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_load(tmr_load),
        .i_value(tmr_value),
        .o_done(tmr_done)
    );

    // two-flop synchronisers for pins, plus edge history
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            {run_m, run_s, run_d, pwr_m, pwr_s} <= 5'h00;
            {din_m, din_s, din_d} <= 6'h00;
        end else begin
            // power needs its level only
            {run_m, run_s, run_d} <= {i_run, run_m, run_s};
            {pwr_m, pwr_s} <= {i_power_ok, pwr_m};
            {din_m, din_s, din_d} <= {i_din, din_m, din_s};
        end
    end

    // millisecond tick paces the sweep and the ramp
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ms_pre <= '0;
            ms_tick <= 1'b0;
        end else begin
            // registered tick, one clean pulse
            ms_tick <= (ms_pre == MW'(MS_TICKS - 1));
            ms_pre <= ms_tick ? '0 : ms_pre + MW'(1);
        end
    end

    // register writes; exit current, decel time and search delay clamped to legal ranges
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            method_sel <= RST_METHOD;
            bidir <= RST_BIDIR;
            din_func <= RST_DIN_FUNC;
            exit_cur <= RST_EXIT_CUR;
            decel_time <= RST_DECEL;
            search_delay <= RST_DELAY;
            min_off <= RST_MIN_OFF;
            max_freq <= RST_MAX_FREQ;
            min_freq <= RST_MIN_FREQ;
        end else if (i_wr) begin
            // read-only and unmapped ignored
            unique case (i_addr)
                REG_MODE: begin
                    method_sel <= i_wdata[MODE_SEL_LSB +: 2];
                    bidir <= i_wdata[MODE_BIDIR_BIT];
                end
                REG_DIN_FUNC: din_func <= i_wdata;
                REG_EXIT_CUR: exit_cur <= clamp8(i_wdata[7:0], 8'h00, EXIT_CUR_MAX);
                REG_DECEL: decel_time <= clamp8(i_wdata[7:0], DECEL_MIN, DECEL_MAX);
                REG_DELAY: search_delay <= clamp8(i_wdata[7:0], 8'h00, DELAY_MAX);
                REG_MIN_OFF: min_off <= i_wdata[7:0];
                REG_MAX_FREQ: max_freq <= i_wdata;
                REG_MIN_FREQ: min_freq <= i_wdata;
                default: ;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // sequencer: every path that drops the output passes the off state
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
            method_q <= RST_METHOD;
            recovery <= 1'b0;
            acc <= 24'h000000;
            o_out_enable <= 1'b0;
            o_out_freq <= 16'h0000;
            o_out_dir <= 1'b0;
            o_search_active <= 1'b0;
            o_est_start <= 1'b0;
        end else begin
            o_est_start <= 1'b0;
            if (go_search) begin
                o_search_active <= 1'b1;
                acc <= 24'h000000;
                if (use_sweep) begin
                    // sweep keeps the present direction only
                    state <= ST_SWEEP;
                    o_out_freq <= sweep_start;
                    o_out_enable <= 1'b1;
                end else begin
                    state <= ST_EST;
                    o_est_start <= 1'b1;
                end
            end

            // the case below wins over a search start above
            unique case (state)
                ST_IDLE: begin
                    // plain start without search
                    if (run_rise) begin
                        method_q <= method_sel;
                    end
                    if (idle_start && !start_search) begin
                        state <= ST_RUN;
                        o_out_freq <= min_freq;
                        o_out_enable <= 1'b1;
                    end
                end

                ST_OFF: begin
                    // bridge stays off until the off time has run out
                    if (tmr_done && (!recovery || !run_s)) begin
                        state <= ST_IDLE;
                        recovery <= 1'b0;
                    end else if (tmr_done && pwr_s) begin
                        state <= ST_DELAY;
                    end
                end

                ST_DELAY: begin
                    // loss while waiting: back off
                    if (!run_s || !pwr_s) begin
                        state <= ST_OFF;
                    end
                end

                ST_EST: begin
                    // bridge off while estimating
                    if (lose_out) begin
                        state <= ST_OFF;
                        recovery <= pwr_s ? ss_rise & run_s : run_s;
                        o_search_active <= 1'b0;
                    end else if (i_est_valid) begin
                        // unmatched direction with bidir off restarts from minimum
                        state <= ST_RUN;
                        o_out_freq <= est_keep ? est_freq : min_freq;
                        o_out_dir <= est_keep ? i_est_dir : o_out_dir;
                        o_out_enable <= 1'b1;
                        o_search_active <= 1'b0;
                    end
                end

                ST_SWEEP: begin
                    // loss mid-sweep: back off
                    if (lose_out) begin
                        state <= ST_OFF;
                        o_out_enable <= 1'b0;
                        recovery <= run_s;
                        o_search_active <= 1'b0;
                    end else if (cur_match || o_out_freq <= min_freq) begin
                        state <= ST_RUN;
                        o_search_active <= 1'b0;
                    end else if (ms_tick) begin
                        // step waits a cycle on a tick
                        acc <= acc + {8'h00, span};
                    end else if (sweep_step) begin
                        acc <= acc - thr;
                        o_out_freq <= o_out_freq - 16'h0001;
                    end
                end

                ST_RUN: begin
                    // one unit per ms toward ref
                    if (lose_out) begin
                        // power loss or input search: coast, then search again
                        state <= ST_OFF;
                        o_out_enable <= 1'b0;
                        recovery <= run_s;
                    end else if (ms_tick && o_out_freq < i_freq_ref
                                 && o_out_freq < max_freq) begin
                        o_out_freq <= o_out_freq + 16'h0001;
                    end else if (ms_tick && o_out_freq > i_freq_ref
                                 && o_out_freq > min_freq) begin
                        o_out_freq <= o_out_freq - 16'h0001;
                    end
                end
            endcase
        end
    end
endmodule : mss_speed_search
`default_nettype wire

/* src/mss_pkg.sv */
// shared constants for the motor speed search sequencer
package mss_pkg;
    // timing base
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TENTH_S_NS = 100_000_000;
    localparam int unsigned ONE_MS_NS = 1_000_000;
    localparam int unsigned TENTH_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_CYCLES = ONE_MS_NS / CLK_PERIOD_NS;
    localparam logic [7:0] MS_PER_TENTH = 8'h64;
    // register offsets
    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_DIN_FUNC = 4'h1;
    localparam logic [3:0] REG_EXIT_CUR = 4'h2;
    localparam logic [3:0] REG_DECEL = 4'h3;
    localparam logic [3:0] REG_DELAY = 4'h4;
    localparam logic [3:0] REG_MIN_OFF = 4'h5;
    localparam logic [3:0] REG_MAX_FREQ = 4'h6;
    localparam logic [3:0] REG_MIN_FREQ = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_OUT_FREQ = 4'h9;
    // field positions of the mode register
    localparam int unsigned MODE_SEL_LSB = 0;
    localparam int unsigned MODE_BIDIR_BIT = 2;
    // values after reset and write limits
    localparam logic [1:0] RST_METHOD = 2'h2;
    localparam logic RST_BIDIR = 1'b1;
    localparam logic [15:0] RST_DIN_FUNC = 16'h0000;
    localparam logic [7:0] RST_EXIT_CUR = 8'h78;
    localparam logic [7:0] EXIT_CUR_MAX = 8'hC8;
    localparam logic [7:0] RST_DECEL = 8'h14;
    localparam logic [7:0] DECEL_MIN = 8'h01;
    localparam logic [7:0] DECEL_MAX = 8'h64;
    localparam logic [7:0] RST_DELAY = 8'h02;
    localparam logic [7:0] DELAY_MAX = 8'hC8;
    localparam logic [7:0] RST_MIN_OFF = 8'h05;
    localparam logic [15:0] RST_MAX_FREQ = 16'h0258;
    localparam logic [15:0] RST_MIN_FREQ = 16'h000F;
    // input function codes
    localparam logic [7:0] FUNC_SEARCH1 = 8'h3D;
    localparam logic [7:0] FUNC_SEARCH2 = 8'h3E;
    // sequencer states
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_OFF = 6'h02,
        ST_DELAY = 6'h04,
        ST_EST = 6'h08,
        ST_SWEEP = 6'h10,
        ST_RUN = 6'h20
    } mss_state_t;
endpackage : mss_pkg

/* src/mss_tenth_timer.sv */
// down-counter in tenths of a second with a done level
`timescale 1ns/1ps
`default_nettype none
module mss_tenth_timer
    import mss_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TENTH_CYCLES
) (
    input wire logic i_clk_sys, // system clock
    input wire logic i_resetn, // async reset, active low
    input wire logic i_load, // start a new interval
    input wire logic [7:0] i_value, // interval in tenths
    output logic o_done // interval has run out
);
    localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
    logic [PW-1:0] pre;
    logic [7:0] cnt;

    // prescaler restarts on load so every interval is at least its full length
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pre <= '0;
            cnt <= 8'h00;
            o_done <= 1'b1;
        end else if (i_load) begin
            pre <= '0;
            cnt <= i_value;
            o_done <= (i_value == 8'h00);
        end else if (cnt != 8'h00) begin
            if (pre == PW'(TICK_CYCLES - 1)) begin
                pre <= '0;
                cnt <= cnt - 8'h01;
                o_done <= (cnt == 8'h01);
            end else begin
                pre <= pre + PW'(1);
            end
        end
    end
endmodule : mss_tenth_timer
`default_nettype wire

/* verification/mss_speed_search_assertions.sv */
// port checker for the speed search sequencer
`timescale 1ns/1ps
`default_nettype none
module mss_speed_search_checker
    import mss_pkg::*;
#(
    parameter int unsigned TENTH_TICKS = TENTH_CYCLES,
    parameter int unsigned MS_TICKS = MS_CYCLES
) (
    input wire logic i_clk_sys, // clock
    input wire logic i_resetn, // reset
    input wire logic i_power_ok, // supply
    input wire logic [15:0] i_freq_ref, // reference
    input wire logic [7:0] i_out_current, // current
    input wire logic o_out_enable, // bridge on
    input wire logic [15:0] o_out_freq, // frequency
    input wire logic o_search_active, // searching
    input wire logic o_est_start // estimator request
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    // off counter starts full so the first start after reset is legal
    logic [15:0] off_cnt;
    wire logic sw_on = o_out_enable && o_search_active;
    wire logic run_on = o_out_enable && !o_search_active;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            off_cnt <= 16'hFFFF;
        end else if (o_out_enable) begin
            off_cnt <= 16'h0000;
        end else if (off_cnt != 16'hFFFF) begin
            off_cnt <= off_cnt + 16'h0001;
        end
    end
    // bench keeps the minimum off time at its reset value of 5 tenths
    property p_off_min;
        $rose(o_out_enable) |-> int'(off_cnt) >= 5 * TENTH_TICKS - 1;
    endproperty
    a_off_min: assert property (p_off_min) else $error("bridge back on too soon");
    property p_loss;
        $fell(i_power_ok) |-> ##[1:5] !o_out_enable;
    endproperty
    a_loss: assert property (p_loss) else $error("bridge stays on after supply loss");
    property p_delay;
        $rose(i_power_ok) |=> (!o_out_enable && !o_search_active) [*8];
    endproperty
    a_delay: assert property (p_delay) else $error("search without delay");
    property p_sweep;
        sw_on ##1 sw_on |-> o_out_freq inside {$past(o_out_freq), $past(o_out_freq) - 16'h0001};
    endproperty
    a_sweep: assert property (p_sweep) else $error("sweep not falling by steps");
    property p_exit;
        sw_on && i_out_current < 8'h78 |-> ##[1:2] !o_search_active;
    endproperty
    a_exit: assert property (p_exit) else $error("sweep ignores low current");
    property p_ramp;
        run_on ##1 run_on |-> o_out_freq == $past(o_out_freq)
            || (o_out_freq == $past(o_out_freq) + 16'h0001 && $past(o_out_freq) < $past(i_freq_ref))
            || (o_out_freq == $past(o_out_freq) - 16'h0001 && $past(o_out_freq) > $past(i_freq_ref));
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp not toward reference");
    property p_est_pulse;
        o_est_start |=> !o_est_start && !o_out_enable;
    endproperty
    a_est_pulse: assert property (p_est_pulse) else $error("estimator request too long");
    property p_est_search;
        o_est_start |-> ##[0:1] o_search_active;
    endproperty
    a_est_search: assert property (p_est_search) else $error("estimation not flagged");
    c_sweep: cover property ($rose(o_search_active) && o_out_enable);
    c_est: cover property (o_est_start);
    c_loss: cover property ($fell(i_power_ok));
endmodule : mss_speed_search_checker
bind mss_speed_search mss_speed_search_checker #(.TENTH_TICKS(TENTH_TICKS), .MS_TICKS(MS_TICKS))
    i_chk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_power_ok(i_power_ok),
    .i_freq_ref(i_freq_ref), .i_out_current(i_out_current), .o_out_enable(o_out_enable),
    .o_out_freq(o_out_freq), .o_search_active(o_search_active), .o_est_start(o_est_start));
`default_nettype wire

/* verification/mss_motor_model.sv */
// coasting motor and field estimator stand-in
`timescale 1ns/1ps
`default_nettype none
module mss_motor_model (
    input wire logic i_clk_sys, // clock
    input wire logic i_resetn, // reset
    input wire logic i_est_start, // estimator request
    input wire logic i_out_enable, // bridge on
    input wire logic [15:0] i_out_freq, // drive frequency
    input wire logic [15:0] i_rotor_speed, // shaft frequency
    input wire logic i_rotor_dir, // shaft direction
    input wire logic [3:0] i_est_wait, // answer latency
    output logic o_est_valid, // result strobe
    output logic [15:0] o_est_speed, // estimated frequency
    output logic o_est_dir, // estimated direction
    output logic [7:0] o_current // current, percent
);
    logic [3:0] est_cnt;
    // estimator answers after a chosen latency, slow or prompt
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            est_cnt <= 4'h0;
        end else if (i_est_start) begin
            est_cnt <= i_est_wait;
        end else if (est_cnt != 4'h0) begin
            est_cnt <= est_cnt - 4'h1;
        end
    end
    assign o_est_valid = (est_cnt == 4'h1);
    // outside the strobe the result lines carry junk, never the answer
    assign o_est_speed = o_est_valid ? i_rotor_speed : ~i_rotor_speed;
    assign o_est_dir = o_est_valid ? i_rotor_dir : ~i_rotor_dir;
    // slip keeps current high while the drive runs ahead of the rotor
    assign o_current = !i_out_enable ? 8'h00 : (i_out_freq > i_rotor_speed) ? 8'h96 : 8'h32;
endmodule : mss_motor_model
`default_nettype wire

/* verification/test_mss_speed_search.sv */
// self-checking bench for the speed search sequencer
`timescale 1ns/1ps
`default_nettype none
module test_mss_speed_search
    import mss_pkg::*;
;
    logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_run = 1'b0;
    logic i_power_ok = 1'b1, rotor_dir = 1'b0;
    logic [3:0] i_addr = 4'h0, est_wait = 4'h2;
    logic [1:0] i_din = 2'h0;
    logic [15:0] i_wdata = 16'h0000, i_freq_ref = 16'h0020, rotor = 16'h01F4, rv;
    wire logic [15:0] o_rdata, o_out_freq, est_speed;
    wire logic o_out_enable, o_out_dir, o_search_active, o_est_start, est_valid, est_dir;
    wire logic [7:0] current;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    logic [3:0] da [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA};
    logic [15:0] de [9] = '{16'h0006, 16'h0000, 16'h0078, 16'h0014, 16'h0002, 16'h0005,
        16'h0258, 16'h000F, 16'h0000};
    logic [3:0] ca [5] = '{4'h2, 4'h3, 4'h3, 4'h4, 4'hB};
    logic [15:0] cd [5] = '{16'h00FF, 16'h0000, 16'h00FF, 16'h00FF, 16'h1234};
    logic [15:0] ce [5] = '{16'h00C8, 16'h0001, 16'h0064, 16'h00C8, 16'h0000};
    always #4 i_clk_sys = ~i_clk_sys;
    // short tick parameters keep the tenth-second timers affordable
    mss_speed_search #(.TENTH_TICKS(10), .MS_TICKS(4)) i_mss_speed_search (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_run(i_run), .i_power_ok(i_power_ok),
        .i_din(i_din), .i_freq_ref(i_freq_ref), .i_out_current(current),
        .i_est_valid(est_valid), .i_est_speed(est_speed), .i_est_dir(est_dir),
        .o_out_enable(o_out_enable), .o_out_freq(o_out_freq), .o_out_dir(o_out_dir),
        .o_search_active(o_search_active), .o_est_start(o_est_start));
    mss_motor_model i_mss_motor_model (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_est_start(o_est_start), .i_out_enable(o_out_enable), .i_out_freq(o_out_freq),
        .i_rotor_speed(rotor), .i_rotor_dir(rotor_dir), .i_est_wait(est_wait),
        .o_est_valid(est_valid), .o_est_speed(est_speed), .o_est_dir(est_dir),
        .o_current(current));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    // bounded wait on enable (0), search flag (1) or estimator request (2)
    task automatic wait_sig(input int s, input logic v);
        int k = 0;
        while ((s == 0 ? o_out_enable : s == 1 ? o_search_active : o_est_start) !== v
            && k < 4000) begin
            @(posedge i_clk_sys);
            #1 k = k + 1;
        end
        cmp({15'h0000, k < 4000}, 16'h0001, "wait");
    endtask : wait_sig
    task automatic stop_run;
        @(posedge i_clk_sys) i_run <= 1'b0;
        repeat (80) @(posedge i_clk_sys);
    endtask : stop_run
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // hang guard, well above the few thousand cycles the sequence needs
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        for (int j = 0; j < 9; j++) begin
            rd(da[j], rv);
            cmp(rv, de[j], "default");
        end
        for (int j = 0; j < 5; j++) begin
            wr(ca[j], cd[j]);
            rd(ca[j], rv);
            cmp(rv, ce[j], "clamp");
        end
        wr(REG_EXIT_CUR, 16'h0078);
        wr(REG_DECEL, 16'h0014);
        wr(REG_DELAY, 16'h0002);
        $display("end registers");
        @(posedge i_clk_sys) i_run <= 1'b1;
        wait_sig(0, 1'b1);
        cmp(o_out_freq, 16'h000F, "plain start");
        cmp({15'h0000, o_search_active}, 16'h0000, "no search");
        repeat (200) @(posedge i_clk_sys);
        rd(REG_OUT_FREQ, rv);
        cmp(rv, 16'h0020, "ramp");
        wr(REG_MODE, 16'h0007);
        rd(REG_STATUS, rv);
        cmp({14'h0000, rv[11:10]}, 16'h0002, "method held");
        stop_run();
        @(posedge i_clk_sys) i_run <= 1'b1;
        wait_sig(1, 1'b1);
        cmp(o_out_freq, 16'h0258, "sweep from max");
        wait_sig(1, 1'b0);
        cmp({15'h0000, o_out_freq inside {[16'h01F1:16'h01F4]}}, 16'h0001, "match");
        @(posedge i_clk_sys) i_power_ok <= 1'b0;
        wait_sig(0, 1'b0);
        repeat (100) @(posedge i_clk_sys);
        @(posedge i_clk_sys) i_power_ok <= 1'b1;
        wait_sig(1, 1'b1);
        cmp(o_out_freq, 16'h0258, "resume search");
        wait_sig(1, 1'b0);
        $display("end sweep and recovery");
        stop_run();
        wr(REG_MODE, 16'h0005);
        rotor <= 16'h012C;
        rotor_dir <= 1'b1;
        est_wait <= 4'h9;
        @(posedge i_clk_sys) i_run <= 1'b1;
        wait_sig(2, 1'b1);
        wait_sig(0, 1'b1);
        cmp(o_out_freq, 16'h012C, "estimated speed");
        cmp({15'h0000, o_out_dir}, 16'h0001, "estimated dir");
        stop_run();
        wr(REG_MODE, 16'h0001);
        rotor_dir <= 1'b0;
        est_wait <= 4'h2;
        @(posedge i_clk_sys) i_run <= 1'b1;
        wait_sig(0, 1'b1);
        cmp(o_out_freq, 16'h000F, "one direction");
        cmp({15'h0000, o_out_dir}, 16'h0001, "dir kept");
        wr(REG_DELAY, 16'h000A);
        @(posedge i_clk_sys) i_run <= 1'b0;
        repeat (70) @(posedge i_clk_sys);
        rd(REG_STATUS, rv);
        cmp({10'h000, rv[5:0]}, 16'h0002, "off floor");
        repeat (50) @(posedge i_clk_sys);
        rd(REG_STATUS, rv);
        cmp({10'h000, rv[5:0]}, 16'h0001, "off over");
        wr(REG_DELAY, 16'h0002);
        $display("end estimation");
        wr(REG_DIN_FUNC, 16'h3E3D);
        wr(REG_MODE, 16'h0006);
        i_freq_ref <= 16'h0190;
        @(posedge i_clk_sys) i_din <= 2'h2;
        @(posedge i_clk_sys) i_run <= 1'b1;
        wait_sig(1, 1'b1);
        cmp(o_out_freq, 16'h0190, "sweep from ref");
        wait_sig(1, 1'b0);
        @(posedge i_clk_sys) i_din <= 2'h0;
        stop_run();
        wr(REG_MODE, 16'h0004);
        @(posedge i_clk_sys) i_run <= 1'b1;
        wait_sig(0, 1'b1);
        @(posedge i_clk_sys) i_din <= 2'h1;
        wait_sig(2, 1'b1);
        wait_sig(0, 1'b1);
        cmp(o_out_freq, 16'h012C, "remote estimation");
        $display("end remote input");
        report_and_stop();
    end
endmodule : test_mss_speed_search
`default_nettype wire
